// ===== include/energy_defs.vh
/*
 * constants of the active energy accumulator: register indices, field
 * positions, reset values and timing counts.
 * assumes: included by the design files by bare name; definitions only.
 */
`ifndef ENERGY_DEFS_VH
`define ENERGY_DEFS_VH

// register indices; byte address is four times the index
`define IDX_ENERGY_WORD 8'h01
`define IDX_LINE_ENERGY 8'h03
`define IDX_WAVE_SEL 8'h0d
`define IDX_ACC_MODE 8'h0f
`define IDX_HALF_CYCLES 8'h12
`define IDX_GAIN 8'h1d
`define IDX_DIVIDER 8'h24
`define IDX_WAVE_DATA 8'h30
`define IDX_NOLOAD_THR 8'h31
`define IDX_IRQ_EN_MID 8'hda
`define IDX_IRQ_EN_HIGH 8'hdb
`define IDX_IRQ_ST_MID 8'hdd
`define IDX_IRQ_ST_HIGH 8'hde

// accumulation mode fields
`define ACC_ABS_BIT 0
`define ACC_POS_BIT 1
`define ACC_SIGN_BIT 4
// middle status / enable fields
`define MID_HALF 0
`define MID_OVF 1
`define MID_UNF 2
`define MID_SIGN 3
`define MID_NOLOAD 4
// high status / enable fields
`define HIGH_CYCLE_END_FLAG 2
`define HIGH_WAVE 3
`define HIGH_WAVEFORM_SAMPLING_ENABLE 5
`define HIGH_IRQ_MASK 8'h0c
// waveform source select fields
`define WSRC_LSB 0
`define WSRC_MSB 1
`define WRATE_LSB 2
`define WRATE_MSB 3
`define WSRC_ACTIVE 2'h0
`define WSRC_REACTIVE 2'h1
`define WSRC_VOLTAGE 2'h2

// timing: accumulation sample period in master clocks
`define ACC_TICK_CLKS 3'h5
`define LPF_SHIFT 4
`define PULSE_THRESHOLD 32'h0100_0000
`define PULSE_WIDTH_CLKS 16'h2328

// reset values
`define RST_ZERO8 8'h00
`define RST_NOLOAD 24'h000010

`endif

// ===== hw/power_lowpass.v
/*
 * first order low pass that extracts the mean of a power product.
 * assumes: din is valid on cycles where in_valid is high.
 */
`timescale 1ns/1ps
`default_nettype none
`include "energy_defs.vh"
module power_lowpass #(
    parameter SHIFT = `LPF_SHIFT
) (
    input wire clk,
    input wire rst_n,
    input wire in_valid,
    input wire [23:0] din,
    output reg [23:0] dout
);
    wire signed [24:0] diff;
    wire signed [24:0] step;
    wire signed [24:0] sum;

    assign diff = $signed({din[23], din}) - $signed({dout[23], dout});
    assign step = diff >>> SHIFT;
    assign sum = $signed({dout[23], dout}) + step;

    // y moves a fraction of the error each sample; no multiplier needed
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dout <= 24'h000000;
        end else if (in_valid) begin
            dout <= sum[23:0];
        end
    end
endmodule
`default_nettype wire

// ===== hw/energy_pulse_gen.v
/*
 * energy to frequency converter driving the active-low pulse pin.
 * assumes: contrib is added once per step, already mode-filtered.
 */
`timescale 1ns/1ps
`default_nettype none
`include "energy_defs.vh"
module energy_pulse_gen (
    input wire clk,
    input wire rst_n,
    input wire step,
    input wire [24:0] contrib,
    output reg pulse_n
);
    reg signed [31:0] bucket_reg;
    reg [15:0] width_reg;
    wire signed [31:0] bucket_sum;
    wire fire;

    assign bucket_sum = bucket_reg + {{7{contrib[24]}}, contrib};
    assign fire = step && (bucket_sum >= $signed(`PULSE_THRESHOLD));

    // a full bucket emits one low pulse; negative energy drains the bucket
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bucket_reg <= 32'h0000_0000;
            width_reg <= 16'h0000;
            pulse_n <= 1'b1;
        end else begin
            if (fire) begin
                bucket_reg <= bucket_sum - $signed(`PULSE_THRESHOLD);
            end else if (step) begin
                bucket_reg <= bucket_sum;
            end
            if (fire) begin
                width_reg <= `PULSE_WIDTH_CLKS;
                pulse_n <= 1'b0;
            end else if (width_reg != 16'h0000) begin
                width_reg <= width_reg - 16'h0001;
                pulse_n <= (width_reg == 16'h0001);
            end
        end
    end
endmodule
`default_nettype wire

// ===== hw/active_energy_accumulator.v
/*
 * active energy accumulator with line cycle mode, pulse output,
 * reactive power path, waveform capture and an apb register slave.
 * assumes: sample inputs and strobes come from logic on pclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "energy_defs.vh"
// Functional notes
// - positive flow past 0x7fffff wraps the energy word to 0x800000, keeps rising.
// - negative flow past 0x800000 wraps the energy word to 0x7fffff, keeps falling.
// - half full, overflow and underflow may raise the interrupt, gated by middle enable.
// - power is added into the energy accumulator once every five clocks when the divider is 0 or 1.
// - internal energy accumulator is 49-bit signed.
// - nonzero divider slows accumulation in proportion to its value.
// - default mode accumulates with sign; negative power subtracts.
// - positive-only bit accumulates only positive power; off after reset.
// - absolute bit accumulates magnitude, skipping power below no-load; off after reset.
// - sign-change and no-load detection keep running in every mode.
// - active-low pulse output tracks calibrated power and the accumulation mode.
// - line cycle mode accumulates over a 16-bit half-cycle count.
// - cycle end sets status flag; enabled interrupt holds until software clears it.
// - next line accumulation starts at once; unread result is overwritten.
// - writing the count clears line energy; a nonzero count restarts at next zero crossing.
// - half cycles are counted from the start crossing up to the count.
// - line energy uses the same path and bit weight as the energy word.
// - reactive power is voltage times shifted current, same low pass as active.
// - with source select and sampling enable, reactive samples read at four rates.
// - divider value zero divides by one.
// - energy word is the upper 24 bits of the 49-bit accumulator.
// - with both mode bits set, positive-only wins.
module active_energy_accumulator (
    input wire pclk,
    input wire presetn,
    input wire [11:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [23:0] voltage_sample,
    input wire [23:0] current_sample,
    input wire [23:0] current_shifted_sample,
    input wire sample_strobe,
    input wire zero_cross_strobe,
    output reg irq,
    output wire energy_pulse_out_n
);
    localparam LC_IDLE = 3'b001;
    localparam LC_WAIT = 3'b010;
    localparam LC_RUN = 3'b100;

    // software registers
    reg [7:0] wave_sel_reg;
    reg [7:0] acc_mode_reg;
    reg [15:0] half_cycle_count_reg;
    reg [11:0] gain_reg;
    reg [7:0] divider_reg;
    reg [23:0] noload_thr_reg;
    reg [7:0] irq_en_mid_reg;
    reg [7:0] irq_en_high_reg;
    reg [7:0] irq_st_mid_reg;
    reg [7:0] irq_st_high_reg;
    // datapath state
    reg [48:0] energy_acc_reg;
    reg [48:0] line_acc_reg;
    reg [23:0] line_energy_reg;
    reg [23:0] wave_data_reg;
    reg [2:0] tick_reg;
    reg [7:0] div_cnt_reg;
    reg [15:0] hc_cnt_reg;
    reg [2:0] lc_state_reg;
    reg [2:0] wave_cnt_reg;
    reg sign_reg;
    reg [31:0] prdata_next;
    reg map_hit;

    wire [47:0] p_prod;
    wire [47:0] q_prod;
    wire [23:0] p_lp;
    wire [23:0] q_lp;
    wire [35:0] gain_prod;
    wire [24:0] p_cal;
    wire [24:0] p_mag;
    wire pos_mode;
    wire abs_mode;
    wire no_load;
    reg [24:0] contrib;
    wire tick;
    wire [7:0] div_eff;
    wire div_hit;
    wire acc_step;
    wire [48:0] contrib_ext;
    wire [48:0] energy_sum;
    wire [48:0] line_sum;
    wire [23:0] word_old;
    wire [23:0] word_new;
    wire [7:0] idx;
    wire bus_write;
    wire hc_write;
    wire half_evt;
    wire ovf_evt;
    wire unf_evt;
    wire sign_evt;
    wire cycle_end_flag_evt;
    wire [2:0] rate_mask;
    wire wave_evt;
    wire [7:0] mid_set;
    wire [7:0] high_set;

    // instantaneous active and reactive products, bits 46 to 23 kept
    assign p_prod = $signed(voltage_sample) * $signed(current_sample);
    assign q_prod = $signed(voltage_sample) * $signed(current_shifted_sample);

    // identical low pass on both paths keeps their responses matched
    power_lowpass u_active_lpf (
        .clk(pclk),
        .rst_n(presetn),
        .in_valid(sample_strobe),
        .din(p_prod[46:23]),
        .dout(p_lp)
    );
    power_lowpass u_reactive_lpf (
        .clk(pclk),
        .rst_n(presetn),
        .in_valid(sample_strobe),
        .din(q_prod[46:23]),
        .dout(q_lp)
    );

    // gain calibration: p * (1 + gain / 4096)
    assign gain_prod = $signed(p_lp) * $signed(gain_reg);
    assign p_cal = $signed({p_lp[23], p_lp}) + $signed({gain_prod[35], gain_prod[35:12]});
    assign p_mag = p_cal[24] ? (25'h0000000 - p_cal) : p_cal;
    assign no_load = (p_mag < {1'b0, noload_thr_reg});

    // mode selection; positive-only overrides absolute
    assign pos_mode = acc_mode_reg[`ACC_POS_BIT];
    assign abs_mode = acc_mode_reg[`ACC_ABS_BIT] && !pos_mode;

    always @* begin
        contrib = p_cal;
        if (no_load) begin
            contrib = 25'h0000000;
        end else if (pos_mode && p_cal[24]) begin
            contrib = 25'h0000000;
        end else if (abs_mode) begin
            contrib = p_mag;
        end
    end

    // five-clock sample tick, then divider decimation of the ticks;
    // decimation averages like a true divide under steady load but
    // drops detail of power that changes within div_eff ticks
    assign tick = (tick_reg == (`ACC_TICK_CLKS - 3'h1));
    assign div_eff = (divider_reg == 8'h00) ? 8'h01 : divider_reg;
    assign div_hit = (div_cnt_reg >= (div_eff - 8'h01));
    assign acc_step = tick && div_hit;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_reg <= 3'h0;
            div_cnt_reg <= 8'h00;
        end else begin
            tick_reg <= tick ? 3'h0 : tick_reg + 3'h1;
            if (tick) begin
                div_cnt_reg <= div_hit ? 8'h00 : div_cnt_reg + 8'h01;
            end
        end
    end

    // 49-bit signed integration; wrap is plain two's complement
    assign contrib_ext = {{24{contrib[24]}}, contrib};
    assign energy_sum = energy_acc_reg + contrib_ext;
    assign line_sum = line_acc_reg + contrib_ext;
    assign word_old = energy_acc_reg[48:25];
    assign word_new = energy_sum[48:25];

    // wrap and half-full events on the readable word
    assign ovf_evt = acc_step && !contrib[24] && !word_old[23] && word_new[23];
    assign unf_evt = acc_step && contrib[24] && word_old[23] && !word_new[23];
    assign half_evt = acc_step && !ovf_evt && !unf_evt &&
        (((word_old[23:22] == 2'b00) && (word_new[23:22] == 2'b01)) ||
         ((word_old[23:22] == 2'b11) && (word_new[23:22] == 2'b10)));

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            energy_acc_reg <= 49'h0;
        end else if (acc_step) begin
            energy_acc_reg <= energy_sum;
        end
    end

    // sign change of active power, checked on every tick above no-load in every mode
    assign sign_evt = tick && !no_load && (sign_reg != p_cal[24]) &&
        (p_cal[24] != acc_mode_reg[`ACC_SIGN_BIT]);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sign_reg <= 1'b0;
        end else if (tick && !no_load) begin
            sign_reg <= p_cal[24];
        end
    end

    energy_pulse_gen u_pulse (
        .clk(pclk),
        .rst_n(presetn),
        .step(acc_step),
        .contrib(contrib),
        .pulse_n(energy_pulse_out_n)
    );

    // line cycle sequencer
    assign idx = paddr[9:2];
    assign bus_write = psel && penable && pwrite && pready && (paddr[11:10] == 2'b00);
    assign hc_write = bus_write && (idx == `IDX_HALF_CYCLES);
    assign cycle_end_flag_evt = !hc_write && (lc_state_reg == LC_RUN) && zero_cross_strobe &&
        ((hc_cnt_reg + 16'h0001) >= half_cycle_count_reg);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lc_state_reg <= LC_IDLE;
            hc_cnt_reg <= 16'h0000;
            line_acc_reg <= 49'h0;
            line_energy_reg <= 24'h000000;
        end else if (hc_write) begin
            line_acc_reg <= 49'h0;
            line_energy_reg <= 24'h000000;
            hc_cnt_reg <= 16'h0000;
            lc_state_reg <= (pwdata[15:0] == 16'h0000) ? LC_IDLE : LC_WAIT;
        end else begin
            case (lc_state_reg)
                LC_IDLE: begin
                    lc_state_reg <= LC_IDLE;
                end
                LC_WAIT: begin
                    if (zero_cross_strobe) begin
                        lc_state_reg <= LC_RUN;
                    end
                end
                LC_RUN: begin
                    if (cycle_end_flag_evt) begin
                        line_energy_reg <= line_sum[48:25];
                        line_acc_reg <= 49'h0;
                        hc_cnt_reg <= 16'h0000;
                    end else begin
                        if (acc_step) begin
                            line_acc_reg <= line_sum;
                        end
                        if (zero_cross_strobe) begin
                            hc_cnt_reg <= hc_cnt_reg + 16'h0001;
                        end
                    end
                end
                default: begin
                    lc_state_reg <= LC_IDLE;
                end
            endcase
        end
    end

    // waveform capture at base rate divided by 1, 2, 4 or 8
    assign rate_mask = (wave_sel_reg[`WRATE_MSB:`WRATE_LSB] == 2'h0) ? 3'h0 :
                       (wave_sel_reg[`WRATE_MSB:`WRATE_LSB] == 2'h1) ? 3'h1 :
                       (wave_sel_reg[`WRATE_MSB:`WRATE_LSB] == 2'h2) ? 3'h3 : 3'h7;
    assign wave_evt = sample_strobe && irq_en_high_reg[`HIGH_WAVEFORM_SAMPLING_ENABLE] &&
        ((wave_cnt_reg & rate_mask) == 3'h0);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave_cnt_reg <= 3'h0;
            wave_data_reg <= 24'h000000;
        end else begin
            if (sample_strobe) begin
                wave_cnt_reg <= wave_cnt_reg + 3'h1;
            end
            if (wave_evt) begin
                case (wave_sel_reg[`WSRC_MSB:`WSRC_LSB])
                    `WSRC_ACTIVE: wave_data_reg <= p_cal[23:0];
                    `WSRC_REACTIVE: wave_data_reg <= q_lp;
                    `WSRC_VOLTAGE: wave_data_reg <= voltage_sample;
                    default: wave_data_reg <= current_sample;
                endcase
            end
        end
    end

    // sticky status: a set in the same cycle as a clear wins
    assign mid_set = ({7'h00, half_evt} << `MID_HALF) |
                     ({7'h00, ovf_evt} << `MID_OVF) |
                     ({7'h00, unf_evt} << `MID_UNF) |
                     ({7'h00, sign_evt} << `MID_SIGN) |
                     ({7'h00, tick && no_load} << `MID_NOLOAD);
    assign high_set = ({7'h00, cycle_end_flag_evt} << `HIGH_CYCLE_END_FLAG) |
                      ({7'h00, wave_evt} << `HIGH_WAVE);

    // software registers; status bits clear when written with zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave_sel_reg <= `RST_ZERO8;
            acc_mode_reg <= `RST_ZERO8;
            half_cycle_count_reg <= 16'h0000;
            gain_reg <= 12'h000;
            divider_reg <= `RST_ZERO8;
            noload_thr_reg <= `RST_NOLOAD;
            irq_en_mid_reg <= `RST_ZERO8;
            irq_en_high_reg <= `RST_ZERO8;
            irq_st_mid_reg <= `RST_ZERO8;
            irq_st_high_reg <= `RST_ZERO8;
        end else begin
            if (bus_write && idx == `IDX_WAVE_SEL) wave_sel_reg <= pwdata[7:0];
            if (bus_write && idx == `IDX_ACC_MODE) acc_mode_reg <= pwdata[7:0];
            if (hc_write) half_cycle_count_reg <= pwdata[15:0];
            if (bus_write && idx == `IDX_GAIN) gain_reg <= pwdata[11:0];
            if (bus_write && idx == `IDX_DIVIDER) divider_reg <= pwdata[7:0];
            if (bus_write && idx == `IDX_NOLOAD_THR) noload_thr_reg <= pwdata[23:0];
            if (bus_write && idx == `IDX_IRQ_EN_MID) irq_en_mid_reg <= pwdata[7:0];
            if (bus_write && idx == `IDX_IRQ_EN_HIGH) irq_en_high_reg <= pwdata[7:0];
            if (bus_write && idx == `IDX_IRQ_ST_MID) begin
                irq_st_mid_reg <= (irq_st_mid_reg & pwdata[7:0]) | mid_set;
            end else begin
                irq_st_mid_reg <= irq_st_mid_reg | mid_set;
            end
            if (bus_write && idx == `IDX_IRQ_ST_HIGH) begin
                irq_st_high_reg <= (irq_st_high_reg & pwdata[7:0]) | high_set;
            end else begin
                irq_st_high_reg <= irq_st_high_reg | high_set;
            end
        end
    end

    // interrupt level stays up while any enabled flag is set
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= (|(irq_st_mid_reg & irq_en_mid_reg)) ||
                   (|(irq_st_high_reg & irq_en_high_reg & `HIGH_IRQ_MASK));
        end
    end

    // read decode; narrow registers sit in the low bits
    always @* begin
        prdata_next = 32'h0000_0000;
        map_hit = (paddr[11:10] == 2'b00);
        case (idx)
            `IDX_ENERGY_WORD: prdata_next = {8'h00, word_old};
            `IDX_LINE_ENERGY: prdata_next = {8'h00, line_energy_reg};
            `IDX_WAVE_SEL: prdata_next = {24'h000000, wave_sel_reg};
            `IDX_ACC_MODE: prdata_next = {24'h000000, acc_mode_reg};
            `IDX_HALF_CYCLES: prdata_next = {16'h0000, half_cycle_count_reg};
            `IDX_GAIN: prdata_next = {20'h00000, gain_reg};
            `IDX_DIVIDER: prdata_next = {24'h000000, divider_reg};
            `IDX_WAVE_DATA: prdata_next = {8'h00, wave_data_reg};
            `IDX_NOLOAD_THR: prdata_next = {8'h00, noload_thr_reg};
            `IDX_IRQ_EN_MID: prdata_next = {24'h000000, irq_en_mid_reg};
            `IDX_IRQ_EN_HIGH: prdata_next = {24'h000000, irq_en_high_reg};
            `IDX_IRQ_ST_MID: prdata_next = {24'h000000, irq_st_mid_reg};
            `IDX_IRQ_ST_HIGH: prdata_next = {24'h000000, irq_st_high_reg};
            default: map_hit = 1'b0;
        endcase
        if (!map_hit) begin
            prdata_next = 32'h0000_0000;
        end
    end

    // one wait state: registered ready keeps every output on a flop
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !map_hit;
            if (psel && penable && !pready && !pwrite) begin
                prdata <= prdata_next;
            end
        end
    end
endmodule
`default_nettype wire

// ===== testbench/active_energy_accumulator_monitor.sv
/* port checker for the energy accumulator: apb timing, irq release, pulse width.
 * assumes: bound to the top design module, one clock, async active-low reset. */
`timescale 1ns/1ps
`default_nettype none
`include "energy_defs.vh"
module accumulator_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [23:0] voltage_sample,
    input wire logic [23:0] current_sample,
    input wire logic [23:0] current_shifted_sample,
    input wire logic sample_strobe,
    input wire logic zero_cross_strobe,
    input wire logic irq,
    input wire logic energy_pulse_out_n
);
    localparam int PULSE_CLKS = `PULSE_WIDTH_CLKS;
    logic [15:0] low_cnt;
    wire logic wr_done = psel && penable && pwrite && pready;
    // low time of the pulse pin; a counter keeps the width check cheap
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            low_cnt <= 16'h0000;
        else
            low_cnt <= energy_pulse_out_n ? 16'h0000 : low_cnt + 16'h0001;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence access_s;
        psel && penable && !pready;
    endsequence
    sequence done_s;
        pready ##1 !pready;
    endsequence
    AST_READY_AFTER_ACCESS: assert property (access_s |=> done_s)
        else $error("pready not one cycle after access");
    AST_READY_CAUSE: assert property (pready |-> $past(psel && penable))
        else $error("pready without an access");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("pslverr outside pready");
    AST_ERR_UPPER: assert property (pready && paddr[11:10] != 2'b00 |-> pslverr)
        else $error("unmapped upper address not refused");
    AST_ERR_READ_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    AST_RDATA_HOLD: assert property (!$stable(prdata) |-> pready)
        else $error("prdata changed outside pready");
    AST_IRQ_CLEAR: assert property ($fell(irq) |-> $past(wr_done) || $past(wr_done, 2))
        else $error("irq dropped without a write");
    AST_PULSE_WIDTH: assert property ($rose(energy_pulse_out_n) |-> low_cnt == PULSE_CLKS)
        else $error("energy pulse width wrong");
endmodule
bind active_energy_accumulator accumulator_monitor mon_u (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .voltage_sample(voltage_sample),
    .current_sample(current_sample), .current_shifted_sample(current_shifted_sample),
    .sample_strobe(sample_strobe), .zero_cross_strobe(zero_cross_strobe), .irq(irq),
    .energy_pulse_out_n(energy_pulse_out_n));
`default_nettype wire

// ===== testbench/sample_source.sv
/* voltage channel and current sample source feeding the accumulator.
 * assumes: same clock and reset as the accumulator. */
`timescale 1ns/1ps
`default_nettype none
module sample_source #(
    parameter int STROBE_GAP = 8,
    parameter int CROSS_GAP = 64
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic [23:0] voltage_sample,
    output logic [23:0] current_sample,
    output logic [23:0] current_shifted_sample,
    output logic sample_strobe,
    output logic zero_cross_strobe
);
    int tick;
    logic pos;
    // half-cycle timer; the voltage swaps sign at every crossing
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick <= 0;
            pos <= 1'b1;
        end else begin
            tick <= (tick == CROSS_GAP - 1) ? 0 : tick + 1;
            if (tick == CROSS_GAP - 1)
                pos <= ~pos;
        end
    end
    // currents stay zero so every power product is zero and expectations stay exact
    assign voltage_sample = pos ? 24'h400000 : 24'hc00000;
    assign current_sample = 24'h000000;
    assign current_shifted_sample = 24'h000000;
    assign sample_strobe = (tick % STROBE_GAP) == 0;
    assign zero_cross_strobe = tick == CROSS_GAP - 1;
endmodule
`default_nettype wire

// ===== testbench/test_active_energy_accumulator.sv
/* self-checking bench: apb register tasks and sequences of calls.
 * assumes: sample_source drives the sample side, zero power throughout. */
`timescale 1ns/1ps
`default_nettype none
`include "energy_defs.vh"
module test_active_energy_accumulator;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq, pulse_n, smp, zc;
    logic [23:0] v_s, i_s, q_s;
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;
    int zc_seen = 0;
    int zc_mark;
    logic [31:0] rd;
    logic err;
    logic [7:0] ridx [8] = '{`IDX_ACC_MODE, `IDX_HALF_CYCLES, `IDX_GAIN, `IDX_DIVIDER,
        `IDX_NOLOAD_THR, `IDX_IRQ_EN_MID, `IDX_IRQ_EN_HIGH, `IDX_WAVE_SEL};
    logic [31:0] rmask [8] = '{32'hff, 32'hffff, 32'hfff, 32'hff, 32'hffffff, 32'hff,
        32'hff, 32'hff};
    logic [31:0] rrst [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h10, 32'h0, 32'h0, 32'h0};

    initial forever #5 pclk = ~pclk;
    // crossings counted on the falling edge, clear of the write edge race
    always @(negedge pclk) zc_seen += (zc === 1'b1);
    // hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_of_test();
        end
    end

    sample_source src_u (.pclk(pclk), .presetn(presetn), .voltage_sample(v_s),
        .current_sample(i_s), .current_shifted_sample(q_s), .sample_strobe(smp),
        .zero_cross_strobe(zc));
    active_energy_accumulator dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .voltage_sample(v_s), .current_sample(i_s),
        .current_shifted_sample(q_s), .sample_strobe(smp), .zero_cross_strobe(zc),
        .irq(irq), .energy_pulse_out_n(pulse_n));

    task end_of_test;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task check(input string name, input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, want, seen);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rchk(input string name, input logic [7:0] idx, input logic [31:0] want);
        apb(1'b0, idx, 32'h0);
        check(name, rd, want);
    endtask

    task wait_irq;
        while (irq !== 1'b1) @(posedge pclk);
    endtask

    // main sequence
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            rchk("reset value", ridx[k], rrst[k]);
            apb(1'b1, ridx[k], 32'hffffffff);
            rchk("field width", ridx[k], rmask[k]);
            apb(1'b1, ridx[k], rrst[k]);
        end
        apb(1'b1, `IDX_ENERGY_WORD, 32'h00123456);
        rchk("energy word", `IDX_ENERGY_WORD, 32'h0);
        apb(1'b0, 8'h00, 32'h0);
        check("unmapped error", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0);
        // modes must keep no-load detection alive and add nothing at zero power
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, `IDX_ACC_MODE, 32'(m));
            apb(1'b1, `IDX_IRQ_ST_MID, 32'h0);
            repeat (40) @(posedge pclk);
            apb(1'b0, `IDX_IRQ_ST_MID, 32'h0);
            check("no-load flag", rd & 32'h10, 32'h10);
            rchk("energy word", `IDX_ENERGY_WORD, 32'h0);
        end
        apb(1'b1, `IDX_ACC_MODE, 32'h0);
        apb(1'b1, `IDX_IRQ_EN_HIGH, 32'h20);
        for (int r = 0; r < 4; r++) begin
            apb(1'b1, `IDX_WAVE_SEL, 32'((r << 2) | 1));
            rchk("wave select", `IDX_WAVE_SEL, 32'((r << 2) | 1));
            repeat (80) @(posedge pclk);
            rchk("reactive sample", `IDX_WAVE_DATA, 32'h0);
        end
        // line cycle: start crossing plus three counted, then an immediate restart
        apb(1'b1, `IDX_IRQ_EN_HIGH, 32'h04);
        apb(1'b1, `IDX_IRQ_ST_HIGH, 32'h0);
        apb(1'b1, `IDX_HALF_CYCLES, 32'h3);
        zc_mark = zc_seen;
        wait_irq();
        check("crossings to end", 32'(zc_seen - zc_mark), 32'h4);
        zc_mark = zc_seen;
        apb(1'b0, `IDX_IRQ_ST_HIGH, 32'h0);
        check("cycle end flag", rd & 32'h4, 32'h4);
        rchk("line energy", `IDX_LINE_ENERGY, 32'h0);
        apb(1'b1, `IDX_IRQ_ST_HIGH, 32'h0);
        repeat (2) @(posedge pclk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        wait_irq();
        check("crossings restart", 32'(zc_seen - zc_mark), 32'h3);
        check("pulse idle", {31'h0, pulse_n}, 32'h1);
        end_of_test();
    end
endmodule
`default_nettype wire
